// ### hw/gss_if.sv
interface gss_if;
    logic [gss_pkg::NUM_TRG-1:0] trg;
    modport dev  (input  trg);
    modport host (output trg);
endinterface : gss_if

// ### hw/gss_pkg.sv
package gss_pkg;
    localparam int NUM_CH      = 24;
    localparam int RES_W       = 12;
    localparam int SST_W       = 8;
    localparam int TRG_W       = 4;
    localparam int NUM_TRG     = 16;
    // Wishbone register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STAT_OFS   = 8'h04;
    localparam logic [7:0] MASKA_OFS  = 8'h08;
    localparam logic [7:0] MASKB_OFS  = 8'h0C;
    localparam logic [7:0] TRGSEL_OFS = 8'h10;
    localparam logic [7:0] SSTC_OFS   = 8'h14;
    localparam logic [7:0] RES_OFS    = 8'h40;
    // Control register fields
    localparam int CTRL_MODE_LO  = 0;
    localparam int CTRL_TRIGGER_START_ENABLE     = 2;
    localparam int CTRL_IEA      = 3;
    localparam int CTRL_IEB      = 4;
    localparam int CTRL_HS       = 5;
    localparam int CTRL_PRIO     = 6;
    localparam int CTRL_ASYNC    = 7;
    localparam int CTRL_MSTOP    = 8;
    localparam logic [1:0] MODE_GROUP = 2'h1;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0100;
    // Status fields
    localparam int STAT_START  = 0;
    localparam int STAT_PENDA  = 1;
    localparam int STAT_PENDB  = 2;
    localparam int STAT_BUSYB  = 3;
    // Conversion timing in conversion-clock states
    localparam int SAR_HS_STATES = 32;
    localparam int SAR_LC_STATES = 41;
    localparam logic [SST_W-1:0] SSTC_RST = 8'h0D;
    localparam int CLK_DIV = 1;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10,
        ST_NEXT   = 2'b11
    } gss_state_e;
endpackage : gss_pkg

// ### hw/gss_sequencer.sv
// Register access over Wishbone and the register offsets are this design's own decisions.
module gss_sequencer #(
    parameter int NCH = gss_pkg::NUM_CH
) (
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic                      wb_we_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic [gss_pkg::RES_W-1:0] sar_result_i,
    output logic [4:0]                     sar_channel_o,
    output logic                           scan_end_irq_o,
    output logic                           group_b_irq_o,
    gss_if.dev                             link
);
    import gss_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic [31:0]      ctrl_q;
    logic [NCH-1:0]   mask_a_q;
    logic [NCH-1:0]   mask_b_q;
    logic [TRG_W-1:0] group_a_trigger_select_q;
    logic [TRG_W-1:0] group_b_trigger_select_q;
    logic [SST_W-1:0] sstc_q;
    logic [RES_W-1:0] result_q [NCH];
    logic             start_q;
    logic             grp_b_q;
    logic             pend_a_q;
    logic             pend_b_q;
    logic [4:0]       ch_q;
    logic [NCH-1:0]   todo_q;
    logic [7:0]       cnt_q;
    gss_state_e       state_q;
    logic             wr;
    logic             trg_a;
    logic             trg_b;
    logic             armed;
    logic             go_a;
    logic             go_b;
    logic             conv_done;
    logic [7:0]       sar_len;
    logic [4:0]       first_ch;
    logic [NCH-1:0]   pick;
    logic             last_ch;
    ////////////////////////////////////////////////////////////////////////
    // Write lands on the edge where the master sees ack
    assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign armed = ctrl_q[CTRL_TRIGGER_START_ENABLE] && !ctrl_q[CTRL_MSTOP] && !ctrl_q[CTRL_ASYNC]
                   && ctrl_q[CTRL_MODE_LO +: 2] == MODE_GROUP;
    assign trg_a = armed && link.trg[group_a_trigger_select_q];
    assign trg_b = armed && link.trg[group_b_trigger_select_q];
    // A may start when idle, or preempt B under priority control
    assign go_a  = trg_a && |mask_a_q && (!start_q || (grp_b_q && ctrl_q[CTRL_PRIO]));
    assign go_b  = trg_b && |mask_b_q && !start_q && !trg_a;
    assign sar_len = ctrl_q[CTRL_HS] ? 8'(SAR_HS_STATES) : 8'(SAR_LC_STATES);
    assign conv_done = state_q == ST_CONV && cnt_q == 8'h00;
    // Lowest set bit of the remaining set
    assign pick = todo_q & (~todo_q + NCH'(1));
    always_comb begin
        first_ch = 5'h00;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pick[i]) begin
                first_ch = 5'(i);
            end
        end
    end
    assign last_ch = (todo_q & ~pick) == '0;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_q   <= CTRL_RST;
            mask_a_q <= '0;
            mask_b_q <= '0;
            group_a_trigger_select_q   <= '0;
            group_b_trigger_select_q   <= '0;
            sstc_q   <= SSTC_RST;
        end else if (wr) begin
            unique case (wb_adr_i)
                CTRL_OFS:   ctrl_q   <= wb_dat_i;
                MASKA_OFS:  mask_a_q <= wb_dat_i[NCH-1:0];
                MASKB_OFS:  mask_b_q <= wb_dat_i[NCH-1:0];
                TRGSEL_OFS: begin
                    group_a_trigger_select_q <= wb_dat_i[TRG_W-1:0];
                    group_b_trigger_select_q <= wb_dat_i[8 +: TRG_W];
                end
                SSTC_OFS:   sstc_q   <= wb_dat_i[SST_W-1:0];
                default:    ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
            grp_b_q <= 1'b0;
            todo_q  <= '0;
            ch_q    <= 5'h00;
            cnt_q   <= 8'h00;
        end else if (go_a || go_b) begin
            start_q <= 1'b1;
            grp_b_q <= go_b;
            todo_q  <= go_a ? mask_a_q : mask_b_q;
            state_q <= ST_NEXT;
        end else if (wr && wb_adr_i == CTRL_OFS && wb_dat_i[CTRL_MODE_LO +: 2] == 2'h0) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: ;
                ST_NEXT: begin
                    ch_q    <= first_ch;
                    cnt_q   <= sstc_q;
                    state_q <= ST_SAMPLE;
                end
                ST_SAMPLE: begin
                    if (cnt_q == 8'h00) begin
                        cnt_q   <= sar_len - 8'h01;
                        state_q <= ST_CONV;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_CONV: begin
                    if (cnt_q == 8'h00) begin
                        todo_q <= todo_q & ~pick;
                        if (last_ch) begin
                            state_q <= ST_IDLE;
                            start_q <= 1'b0;
                        end else begin
                            state_q <= ST_NEXT;
                        end
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Hardware set wins over a same-cycle software clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pend_a_q <= 1'b0;
            pend_b_q <= 1'b0;
        end else begin
            if (conv_done && last_ch && !grp_b_q && !go_a) begin
                pend_a_q <= 1'b1;
            end else if (wr && wb_adr_i == STAT_OFS && !wb_dat_i[STAT_PENDA]) begin
                pend_a_q <= 1'b0;
            end
            if (conv_done && last_ch && grp_b_q && !go_a) begin
                pend_b_q <= 1'b1;
            end else if (wr && wb_adr_i == STAT_OFS && !wb_dat_i[STAT_PENDB]) begin
                pend_b_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            scan_end_irq_o <= 1'b0;
            group_b_irq_o  <= 1'b0;
            sar_channel_o  <= 5'h00;
        end else begin
            scan_end_irq_o <= pend_a_q && ctrl_q[CTRL_IEA];
            group_b_irq_o  <= pend_b_q && ctrl_q[CTRL_IEB];
            sar_channel_o  <= ch_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NCH; i++) begin
                result_q[i] <= '0;
            end
        end else if (conv_done && !go_a) begin
            result_q[ch_q] <= sar_result_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i >= RES_OFS && wb_adr_i < RES_OFS + 8'(4 * NCH)) begin
                wb_dat_o <= 32'(result_q[5'((wb_adr_i - RES_OFS) >> 2)]);
            end else begin
                unique case (wb_adr_i)
                    CTRL_OFS:   wb_dat_o <= ctrl_q;
                    STAT_OFS:   wb_dat_o <= {28'h0, grp_b_q && start_q, pend_b_q, pend_a_q, start_q};
                    MASKA_OFS:  wb_dat_o <= 32'(mask_a_q);
                    MASKB_OFS:  wb_dat_o <= 32'(mask_b_q);
                    TRGSEL_OFS: wb_dat_o <= {20'h0, group_b_trigger_select_q, 4'h0, group_a_trigger_select_q};
                    SSTC_OFS:   wb_dat_o <= 32'(sstc_q);
                    default:    wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : gss_sequencer

// ### hw/gss_trig_src.sv
module gss_trig_src (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    input  wire logic [gss_pkg::NUM_TRG-1:0] event_i,
    gss_if.host                              link
);
    import gss_pkg::*;
    logic [NUM_TRG-1:0] trg_q;
    // Timer events leave registered, one cycle late and as long as they came in
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            trg_q <= '0;
        end else begin
            trg_q <= event_i;
        end
    end
    assign link.trg = trg_q;
endmodule : gss_trig_src

// ### test/gss_assertions.sv
module gss_assertions (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] event_i,
    input wire logic [15:0] trg,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [4:0]  sar_channel_o,
    input wire logic        scan_end_irq_o,
    input wire logic        group_b_irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    trg_delay_a: assert property (!$past(rst_i) |-> trg == $past(event_i))
        else $error("trigger line not one cycle behind event");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    ack_cyc_a: assert property (wb_ack_o |-> wb_cyc_i)
        else $error("ack outside bus cycle");
    // Pending only leaves through a bus write, never by itself
    irq_a_hold_a: assert property ($fell(scan_end_irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("group A irq dropped without write");
    irq_b_hold_a: assert property ($fell(group_b_irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("group B irq dropped without write");
    // Sampling plus conversion keeps a channel far longer than three cycles
    chan_hold_a: assert property ($changed(sar_channel_o) |=> $stable(sar_channel_o) [*2])
        else $error("channel switched too soon");
endmodule : gss_assertions

// ### test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import gss_pkg::*;
    `define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; $display("Error %s exp %0h got %0h", n, e, a); end end
    logic        sys_clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, lfsr = 32'h4780, ma, mb;
    logic [15:0] ev = 16'h0;
    logic [11:0] res = 12'h0, key = 12'h0;
    logic [4:0]  last, q[$];
    wire  [31:0] dat_o;
    wire  [4:0]  ch;
    wire         ack, irqa, irqb;
    int          err_count = 0, cmp_count = 0, cyc_n = 0;
    gss_if link_if();
    gss_trig_src i_gss_trig_src (.sys_clk_i, .rst_i, .event_i(ev), .link(link_if));
    gss_sequencer i_gss_sequencer (.sys_clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .sar_result_i(res), .sar_channel_o(ch),
        .scan_end_irq_o(irqa), .group_b_irq_o(irqb), .link(link_if));
    gss_assertions i_gss_assertions (.sys_clk_i, .rst_i, .event_i(ev), .trg(link_if.trg), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .sar_channel_o(ch), .scan_end_irq_o(irqa), .group_b_irq_o(irqb));
    ////////////////////////////////////////////////////////////
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        res <= {ch, 7'h55} ^ key;
        if (ch !== last) q.push_back(ch);
        last = ch;
        cyc_n++;
        if (cyc_n == 20000) begin
            err_count++;
            test_done();
        end
    end
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge sys_clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic pulse(input int b);
        @(posedge sys_clk_i);
        ev[b] <= 1'b1;
        @(posedge sys_clk_i);
        ev <= 16'h0;
    endtask : pulse
    // Second pulse lands while the first channel samples; a restart would stretch the scan time
    task automatic run(input int b, input logic [23:0] m, input int conv);
        int t0, n, p, c;
        q.delete();
        key <= lfsr[11:0];
        lfsr = nx(lfsr);
        pulse(b);
        t0 = cyc_n;
        pulse(b);
        wb(0, STAT_OFS, 0);
        `CHK("start flag", 1'b1, rdat[STAT_START])
        while (rdat[STAT_START] === 1'b1) wb(0, STAT_OFS, 0);
        n = $countones(m);
        t0 = cyc_n - t0 - n * (conv + 90);
        `CHK("scan time", 1'b1, t0 >= -2 && t0 <= 10)
        p = 0;
        c = 0;
        for (int k = 0; k < 24; k++) begin
            if (m[k]) begin
                wb(0, RES_OFS + 8'(4 * k), 0);
                `CHK("result", {20'h0, {5'(k), 7'h55} ^ key}, rdat)
                while (p < q.size() && q[p] !== 5'(k)) p++;
                if (p < q.size()) c++;
            end
        end
        `CHK("order", n, c)
        $display("scan of trigger %0d done", b);
    endtask : run
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wb(0, CTRL_OFS, 0);
        `CHK("ctrl reset", CTRL_RST, rdat)
        wb(0, SSTC_OFS, 0);
        `CHK("count reset", 32'(SSTC_RST), rdat)
        wb(1, 8'h3C, 32'hFFFFFFFF);
        wb(0, 8'h3C, 0);
        `CHK("unmapped", 32'h0, rdat)
        $display("reset test done");
        ma = {8'h0, lfsr[23:0]};
        mb = {8'h0, ~lfsr[23:0]};
        lfsr = nx(lfsr);
        wb(1, CTRL_OFS, 0);
        wb(1, MASKA_OFS, ma);
        wb(1, MASKB_OFS, mb);
        wb(1, TRGSEL_OFS, 32'h0000_0201);
        wb(1, SSTC_OFS, 32'h58);
        wb(1, CTRL_OFS, 32'h29);
        pulse(1);
        repeat (4) @(posedge sys_clk_i);
        wb(0, STAT_OFS, 0);
        `CHK("no start", 1'b0, rdat[STAT_START])
        wb(1, CTRL_OFS, 32'h2D);
        run(1, ma, SAR_HS_STATES);
        `CHK("irq a", 1'b1, irqa)
        // Low-current mode, group B request masked
        wb(1, CTRL_OFS, 32'h0D);
        run(2, mb, SAR_LC_STATES);
        wb(0, STAT_OFS, 0);
        `CHK("pending", 2'b11, rdat[2:1])
        `CHK("irq b off", 1'b0, irqb)
        wb(1, CTRL_OFS, 32'h1D);
        repeat (2) @(posedge sys_clk_i);
        `CHK("irq b", 1'b1, irqb)
        wb(1, STAT_OFS, 0);
        repeat (2) @(posedge sys_clk_i);
        wb(0, STAT_OFS, 0);
        `CHK("cleared", 4'h0, {rdat[2:1], irqa, irqb})
        $display("irq test done");
        wb(1, CTRL_OFS, 32'h65);
        pulse(2);
        repeat (40) @(posedge sys_clk_i);
        wb(0, STAT_OFS, 0);
        `CHK("b busy", 2'b11, {rdat[STAT_BUSYB], rdat[STAT_START]})
        run(1, ma, SAR_HS_STATES);
        wb(0, STAT_OFS, 0);
        `CHK("preempt", 2'b01, rdat[2:1])
        // Mode 0 write must stop a running scan
        pulse(1);
        wb(0, STAT_OFS, 0);
        `CHK("restart", 1'b1, rdat[STAT_START])
        wb(1, CTRL_OFS, 32'h0);
        wb(0, STAT_OFS, 0);
        `CHK("abort", 1'b0, rdat[STAT_START])
        $display("abort test done");
        test_done();
    end
endmodule : tb
